// >>> i2c_slave_port_tb_top.sv
// self-checking bench for the two-wire slave port
// assumes isp_master drives the far side of the pins
module i2c_slave_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] a_own = isp_pkg::own_address_idx;
    localparam logic [7:0] a_buf = isp_pkg::transfer_buffer_idx;
    localparam logic [7:0] a_cfg = isp_pkg::link_config_idx;
    localparam logic [7:0] a_ien = isp_pkg::irq_enable_one_idx;
    localparam logic [7:0] a_st  = isp_pkg::link_status_idx;
    localparam logic [7:0] a_flg = isp_pkg::irq_flag_one_idx;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, d;
    logic        scl_out, scl_oe, sda_out, sda_oe, slew, irq, m_scl, m_sda;
    logic        scl, sda, a, e;
    logic [7:0]  r;
    int          err_total, n_compared, cyc;
    // open-drain lines with pull-ups
    assign scl = ~((scl_oe & ~scl_out) | m_scl);
    assign sda = ~((sda_oe & ~sda_out) | m_sda);
    isp_slave u_isp_slave (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
        .sda_oe(sda_oe), .slew_limit_off(slew), .irq(irq));
    isp_master u_isp_master (.pclk(pclk), .scl(scl), .sda(sda),
        .scl_low(m_scl), .sda_low(m_sda));
    // 20 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            err_total++;
            end_sim();
        end
    end
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer, setup then access until pready
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        // wait for pready; if it never comes, only the hang guard ends this wait
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let a written register reach the registered outputs
        repeat (2) @(posedge pclk);
    endtask : apb
    // masked register read compare
    task automatic rm(input logic [7:0] i, input logic [7:0] m, input logic [7:0] x);
        apb(1'b0, i, 8'h00);
        check(d & {24'h0, m}, {24'h0, x});
    endtask : rm
    // reset values, unmapped access, disabled port
    task automatic t_reset;
        rm(a_own, 8'hff, 8'h00);
        rm(a_buf, 8'hff, 8'h00);
        rm(a_cfg, 8'hff, 8'h10);
        rm(a_st, 8'hff, 8'h44);
        rm(a_ien, 8'hff, 8'h00);
        rm(a_flg, 8'hff, 8'h00);
        apb(1'b0, 8'h10, 8'h00);
        check(e, 1'b1);
        apb(1'b1, a_own, 8'ha5);
        rm(a_own, 8'hff, 8'ha4);
        u_isp_master.start();
        u_isp_master.xfer(8'ha4, 1'b1, r, a);
        check(a, 1'b1);
        u_isp_master.stop();
        $display("t_reset done");
    endtask : t_reset
    // master write: mismatch, match, data, overrun, irq
    task automatic t_write;
        apb(1'b1, a_cfg, 8'h15);
        apb(1'b1, a_ien, 8'h08);
        u_isp_master.start();
        u_isp_master.xfer(8'hb0, 1'b1, r, a);
        check(a, 1'b1);
        u_isp_master.start();
        u_isp_master.xfer(8'ha4, 1'b1, r, a);
        check(a, 1'b0);
        rm(a_st, 8'hb0, 8'h80);
        check(irq, 1'b1);
        apb(1'b1, a_ien, 8'h00);
        check(irq, 1'b0);
        rm(a_flg, 8'h08, 8'h08);
        apb(1'b1, a_flg, 8'h00);
        apb(1'b1, a_ien, 8'h08);
        u_isp_master.xfer(8'h3c, 1'b1, r, a);
        check(a, 1'b0);
        rm(a_st, 8'h18, 8'h18);
        check(irq, 1'b1);
        u_isp_master.xfer(8'h77, 1'b1, r, a);
        check(a, 1'b1);
        rm(a_buf, 8'hff, 8'h3c);
        rm(a_st, 8'h09, 8'h01);
        apb(1'b1, a_st, 8'h00);
        rm(a_st, 8'h01, 8'h00);
        u_isp_master.stop();
        rm(a_st, 8'hc0, 8'h40);
        apb(1'b1, a_flg, 8'h00);
        $display("t_write done");
    endtask : t_write
    // master read with stretch, collision and master nack
    task automatic t_read;
        u_isp_master.start();
        u_isp_master.xfer(8'ha5, 1'b1, r, a);
        check(a, 1'b0);
        rm(a_st, 8'h30, 8'h20);
        fork
            u_isp_master.xfer(8'hff, 1'b1, r, a);
            begin
                repeat (40) @(posedge pclk);
                check(scl_oe, 1'b1);
                apb(1'b1, a_buf, 8'h96);
                repeat (10) @(posedge pclk);
                apb(1'b1, a_buf, 8'h11);
                rm(a_st, 8'h0a, 8'h0a);
            end
        join
        check(r, 8'h96);
        rm(a_st, 8'h0c, 8'h04);
        u_isp_master.stop();
        apb(1'b1, a_st, 8'h00);
        $display("t_read done");
    endtask : t_read
    // write stretch, forced hold, slew, soft reset
    task automatic t_config;
        apb(1'b1, a_cfg, 8'h0d);
        u_isp_master.start();
        u_isp_master.xfer(8'ha4, 1'b1, r, a);
        fork
            begin
                u_isp_master.xfer(8'h5a, 1'b1, r, a);
                u_isp_master.stop();
            end
            begin
                for (int k = 0; k < 400 && scl_oe !== 1'b1; k++) @(posedge pclk);
                repeat (20) @(posedge pclk);
                check(scl_oe, 1'b1);
                rm(a_buf, 8'hff, 8'h5a);
            end
        join
        apb(1'b1, a_cfg, 8'h01);
        check(scl_oe, 1'b1);
        apb(1'b1, a_cfg, 8'h03);
        check(slew, 1'b1);
        apb(1'b1, a_cfg, 8'h21);
        check(scl_oe, 1'b0);
        rm(a_st, 8'hff, 8'h44);
        rm(a_buf, 8'hff, 8'h00);
        apb(1'b1, a_cfg, 8'h05);
        check(slew, 1'b0);
        $display("t_config done");
    endtask : t_config
    // verdict and end of run
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // reset, then the scenarios in turn
    initial
    begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 10'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_write();
        t_read();
        t_config();
        end_sim();
    end
endmodule : i2c_slave_port_tb_top

// >>> isp_master.sv
// bus master model for the two-wire slave port
// assumes both lines pulled up and resolved by the bench
module isp_master (
    input  wire logic pclk,    // system clock
    input  wire logic scl,     // resolved clock line
    input  wire logic sda,     // resolved data line
    output logic      scl_low, // pulls clock low
    output logic      sda_low  // pulls data low
);
    timeunit 1ns;
    timeprecision 1ns;
    // lines idle high, clock still outside frames
    initial {scl_low, sda_low} = 2'b00;
    // quarter of a 400 ns link period
    task automatic q(input int n);
        repeat (2 * n) @(posedge pclk);
    endtask : q
    // release clock, wait while the slave stretches
    task automatic rise;
        scl_low <= 1'b0;
        do
            @(posedge pclk);
        while (scl !== 1'b1);
    endtask : rise
    // start, also repeated start
    task automatic start;
        sda_low <= 1'b0;
        q(1);
        rise();
        q(1);
        sda_low <= 1'b1;
        q(2);
        scl_low <= 1'b1;
        q(1);
    endtask : start
    // stop condition
    task automatic stop;
        sda_low <= 1'b1;
        q(1);
        rise();
        q(2);
        sda_low <= 1'b0;
        q(2);
    endtask : stop
    // one bit out, line sampled while clock high
    task automatic bit_io(input logic b, output logic r);
        sda_low <= ~b;
        q(1);
        rise();
        @(posedge pclk);
        r = sda;
        q(1);
        scl_low <= 1'b1;
        q(1);
    endtask : bit_io
    // eight bits msb first, then the acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(last, a);
    endtask : xfer
endmodule : isp_master

// >>> isp_pkg.sv
// constants for the two-wire slave port: register indices, bit positions, resets
// assumes an apb slave wrapper with 10-bit byte addresses, register byte = 4 * index
package isp_pkg;
    // register indices (byte address is index * 4)
    localparam logic [7:0] own_address_idx     = 8'he3;
    localparam logic [7:0] transfer_buffer_idx = 8'he4;
    localparam logic [7:0] link_config_idx     = 8'he5;
    localparam logic [7:0] irq_enable_one_idx  = 8'he6;
    localparam logic [7:0] irq_enable_two_idx  = 8'he7;
    localparam logic [7:0] link_status_idx     = 8'he8;
    localparam logic [7:0] irq_flag_one_idx    = 8'hf1;
    // link_config bit positions
    localparam int cfg_link_enable   = 0;
    localparam int cfg_slew_off      = 1;
    localparam int cfg_clock_release = 2;
    localparam int cfg_wr_stretch    = 3;
    localparam int cfg_rd_stretch    = 4;
    localparam int cfg_soft_reset    = 5;
    // link_status bit positions
    localparam int st_start_seen  = 7;
    localparam int st_stop_seen   = 6;
    localparam int st_last_dir    = 5;
    localparam int st_data_flag   = 4;
    localparam int st_buffer_full = 3;
    localparam int st_nack_seen   = 2;
    localparam int st_write_coll  = 1;
    localparam int st_overrun     = 0;
    // serial port enable and flag position in the interrupt registers
    localparam int irq_bit = 3;
    // reset values
    localparam logic [5:0] config_reset = 6'h10;
    localparam logic [7:0] buffer_reset = 8'h00;
    localparam logic [7:0] status_reset = 8'h44;
    // last bit index and bit count of a byte
    localparam logic [3:0] last_bit   = 4'h7;
    localparam logic [3:0] bits_per_b = 4'h8;
    // link state machine
    typedef enum logic [2:0] {
        st_idle, st_addr, st_aack, st_rx, st_rack, st_txw, st_tx, st_tack
    } isp_state_type;
endpackage : isp_pkg

// >>> isp_slave.sv
// two-wire slave port with apb register access, all logic in one module
// assumes scl and sda arrive from pins, open drain resolved outside
//
// Function
// - soft reset bit holds link logic reset
// - read stretch bit holds clock before send
// - write stretch bit holds clock after receive
// - clock release bit zero holds clock low
// - slew bit drives edge-rate select output
// - own address held in bits seven..one
// - one shared buffer for both directions
// - start flag set on start condition
// - stop flag set on stop, resets one
// - direction of matched address is latched
// - flag shows data or address byte
// - buffer full set after byte received
// - buffer full high while byte shifts out
// - nack flag records master acknowledge
// - write during send rejected, collision set
// - byte over unread buffer sets overrun
// - enable bit three gates interrupt request
// - flag bit three records pending interrupt
//
// Our own choice: the APB interface to the registers.
module isp_slave (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             slew_limit_off,
    output logic             irq
);
    // whole module state
    typedef struct packed {
        logic [1:0]              scl_s;      // clock synchroniser
        logic [1:0]              sda_s;      // data synchroniser
        logic                    scl_q;      // previous synced clock
        logic                    sda_q;      // previous synced data
        isp_pkg::isp_state_type  fsm;        // link state
        logic [3:0]              cnt;        // bit counter
        logic                    phase;      // ack half
        logic [7:0]              shift;      // shift register
        logic                    ack_ok;     // ack to drive
        logic                    hold;       // stretch request
        logic [6:0]              own;        // own address
        logic [7:0]              buffer;     // transfer buffer
        logic [5:0]              cfg;        // link config
        logic [7:2]              interrupt_enable_one;       // irq enable one
        logic [3:0]              interrupt_enable_two;       // irq enable two
        logic [7:0]              stat;       // link status
        logic                    ie_flag;    // pending interrupt
        logic                    scl_oe;     // clock pull low
        logic                    sda_oe;     // data pull low
        logic                    slew;       // edge-rate select
        logic                    irq;        // interrupt to core
        logic [7:0]              rdata;      // read data
        logic                    pready;     // apb ready
        logic                    pslverr;    // apb error
    } isp_regs_type;

    isp_regs_type q;
    isp_regs_type next_q;

    // edge and bus condition helpers from second sync stage
    logic rise;
    logic fall;
    logic start_ev;
    logic stop_ev;
    logic wr_acc;
    logic rd_acc;
    logic [7:0] idx;
    logic hit;
    assign rise     = q.scl_s[1] & ~q.scl_q;
    assign fall     = ~q.scl_s[1] & q.scl_q;
    assign start_ev = q.scl_s[1] & q.scl_q & q.sda_q & ~q.sda_s[1];
    assign stop_ev  = q.scl_s[1] & q.scl_q & ~q.sda_q & q.sda_s[1];
    assign wr_acc   = psel & penable & q.pready & pwrite;
    assign rd_acc   = psel & penable & q.pready & ~pwrite;
    assign idx      = paddr[9:2];
    assign hit      = (paddr[1:0] == 2'b00);

    // next state: bus slave, then link, then soft reset
    always_comb
    begin
        next_q = q;
        next_q.scl_s = {q.scl_s[0], scl_in};
        next_q.sda_s = {q.sda_s[0], sda_in};
        next_q.scl_q = q.scl_s[1];
        next_q.sda_q = q.sda_s[1];
        // setup phase: register read data and answer for the access phase
        next_q.pready  = psel & ~penable;
        next_q.pslverr = 1'b0;
        next_q.rdata   = 8'h00;
        if (psel && !penable)
        begin
            unique case (idx)
                isp_pkg::own_address_idx:     next_q.rdata = {q.own, 1'b0};
                isp_pkg::transfer_buffer_idx: next_q.rdata = q.buffer;
                isp_pkg::link_config_idx:     next_q.rdata = {2'b00, q.cfg};
                isp_pkg::irq_enable_one_idx:  next_q.rdata = {q.interrupt_enable_one, 2'b00};
                isp_pkg::irq_enable_two_idx:  next_q.rdata = {4'h0, q.interrupt_enable_two};
                isp_pkg::link_status_idx:     next_q.rdata = q.stat;
                isp_pkg::irq_flag_one_idx:    next_q.rdata = {4'h0, q.ie_flag, 3'h0};
                default:                      next_q.pslverr = 1'b1;
            endcase
            if (!hit)
                next_q.pslverr = 1'b1;
        end
        // access phase writes
        if (wr_acc && hit)
        begin
            unique case (idx)
                isp_pkg::own_address_idx: next_q.own = pwdata[7:1];
                isp_pkg::transfer_buffer_idx:
                begin
                    if (q.fsm == isp_pkg::st_tx)
                        next_q.stat[isp_pkg::st_write_coll] = 1'b1;
                    else
                    begin
                        next_q.buffer = pwdata[7:0];
                        if (q.stat[isp_pkg::st_last_dir])
                            next_q.stat[isp_pkg::st_buffer_full] = 1'b1;
                    end
                end
                isp_pkg::link_config_idx:    next_q.cfg  = pwdata[5:0];
                isp_pkg::irq_enable_one_idx: next_q.interrupt_enable_one = pwdata[7:2];
                isp_pkg::irq_enable_two_idx: next_q.interrupt_enable_two = pwdata[3:0];
                isp_pkg::link_status_idx:
                begin
                    // only zero clears; set from the link below wins
                    if (!pwdata[isp_pkg::st_write_coll])
                        next_q.stat[isp_pkg::st_write_coll] = 1'b0;
                    if (!pwdata[isp_pkg::st_overrun])
                        next_q.stat[isp_pkg::st_overrun] = 1'b0;
                end
                isp_pkg::irq_flag_one_idx:
                    if (!pwdata[isp_pkg::irq_bit])
                        next_q.ie_flag = 1'b0;
                default: ;
            endcase
        end
        // reading a received byte empties the buffer
        if (rd_acc && hit && idx == isp_pkg::transfer_buffer_idx
            && !q.stat[isp_pkg::st_last_dir])
            next_q.stat[isp_pkg::st_buffer_full] = 1'b0;
        // write stretch ends once the byte was read
        if (q.fsm == isp_pkg::st_rx && !next_q.stat[isp_pkg::st_buffer_full])
            next_q.hold = 1'b0;
        // link state machine
        unique case (q.fsm)
            isp_pkg::st_idle: ;
            isp_pkg::st_addr:
                if (rise)
                begin
                    next_q.shift = {q.shift[6:0], q.sda_s[1]};
                    next_q.cnt   = q.cnt + 4'h1;
                    if (q.cnt == isp_pkg::last_bit)
                    begin
                        if (q.shift[6:0] == q.own)
                        begin
                            next_q.fsm    = isp_pkg::st_aack;
                            next_q.phase  = 1'b0;
                            next_q.ack_ok = 1'b1;
                            next_q.stat[isp_pkg::st_last_dir]  = q.sda_s[1];
                            next_q.stat[isp_pkg::st_data_flag] = 1'b0;
                            next_q.ie_flag = 1'b1;
                        end
                        else
                            next_q.fsm = isp_pkg::st_idle;
                    end
                end
            isp_pkg::st_aack, isp_pkg::st_rack:
                if (fall)
                begin
                    if (!q.phase)
                    begin
                        next_q.sda_oe = q.ack_ok;
                        next_q.phase  = 1'b1;
                    end
                    else
                    begin
                        next_q.sda_oe = 1'b0;
                        next_q.phase  = 1'b0;
                        next_q.cnt    = 4'h0;
                        if (q.fsm == isp_pkg::st_aack && q.stat[isp_pkg::st_last_dir])
                            next_q.fsm = isp_pkg::st_txw;
                        else
                        begin
                            next_q.fsm  = isp_pkg::st_rx;
                            next_q.hold = (q.fsm == isp_pkg::st_rack) & q.ack_ok
                                          & q.cfg[isp_pkg::cfg_wr_stretch];
                        end
                    end
                end
            isp_pkg::st_rx:
                if (rise)
                begin
                    next_q.shift = {q.shift[6:0], q.sda_s[1]};
                    next_q.cnt   = q.cnt + 4'h1;
                    if (q.cnt == isp_pkg::last_bit)
                    begin
                        next_q.fsm   = isp_pkg::st_rack;
                        next_q.phase = 1'b0;
                        if (q.stat[isp_pkg::st_buffer_full])
                        begin
                            next_q.stat[isp_pkg::st_overrun] = 1'b1;
                            next_q.ack_ok = 1'b0;
                        end
                        else
                        begin
                            next_q.buffer = {q.shift[6:0], q.sda_s[1]};
                            next_q.stat[isp_pkg::st_buffer_full] = 1'b1;
                            next_q.stat[isp_pkg::st_data_flag]   = 1'b1;
                            next_q.ack_ok  = 1'b1;
                            next_q.ie_flag = 1'b1;
                        end
                    end
                end
            isp_pkg::st_txw:
                // with read stretch set, wait for software data before the first bit
                if (q.stat[isp_pkg::st_buffer_full] || !q.cfg[isp_pkg::cfg_rd_stretch])
                begin
                    next_q.shift  = q.buffer;
                    next_q.sda_oe = ~q.buffer[7];
                    next_q.hold   = 1'b0;
                    next_q.cnt    = 4'h0;
                    next_q.fsm    = isp_pkg::st_tx;
                    next_q.stat[isp_pkg::st_buffer_full] = 1'b1;
                end
                else
                    next_q.hold = 1'b1;
            isp_pkg::st_tx:
                if (rise)
                    next_q.cnt = q.cnt + 4'h1;
                else if (fall)
                begin
                    if (q.cnt == isp_pkg::bits_per_b)
                    begin
                        next_q.sda_oe = 1'b0;
                        next_q.fsm    = isp_pkg::st_tack;
                        next_q.phase  = 1'b0;
                        next_q.stat[isp_pkg::st_buffer_full] = 1'b0;
                        next_q.stat[isp_pkg::st_data_flag]   = 1'b1;
                        next_q.ie_flag = 1'b1;
                    end
                    else
                    begin
                        next_q.shift  = {q.shift[6:0], 1'b0};
                        next_q.sda_oe = ~q.shift[6];
                    end
                end
            isp_pkg::st_tack:
                if (rise)
                begin
                    next_q.stat[isp_pkg::st_nack_seen] = q.sda_s[1];
                    next_q.phase = 1'b1;
                end
                else if (fall && q.phase)
                    next_q.fsm = q.stat[isp_pkg::st_nack_seen] ? isp_pkg::st_idle
                                                               : isp_pkg::st_txw;
        endcase
        // bus conditions override any byte in flight
        if (start_ev)
        begin
            next_q.fsm    = isp_pkg::st_addr;
            next_q.cnt    = 4'h0;
            next_q.sda_oe = 1'b0;
            next_q.hold   = 1'b0;
            next_q.stat[isp_pkg::st_start_seen] = 1'b1;
            next_q.stat[isp_pkg::st_stop_seen]  = 1'b0;
        end
        else if (stop_ev)
        begin
            next_q.fsm    = isp_pkg::st_idle;
            next_q.sda_oe = 1'b0;
            next_q.hold   = 1'b0;
            next_q.stat[isp_pkg::st_stop_seen]  = 1'b1;
            next_q.stat[isp_pkg::st_start_seen] = 1'b0;
        end
        // disabled port stays off the bus
        if (!q.cfg[isp_pkg::cfg_link_enable])
        begin
            next_q.fsm    = isp_pkg::st_idle;
            next_q.sda_oe = 1'b0;
            next_q.hold   = 1'b0;
        end
        // soft reset returns link logic and status to reset values
        if (q.cfg[isp_pkg::cfg_soft_reset])
        begin
            next_q.fsm    = isp_pkg::st_idle;
            next_q.cnt    = 4'h0;
            next_q.phase  = 1'b0;
            next_q.shift  = 8'h00;
            next_q.sda_oe = 1'b0;
            next_q.hold   = 1'b0;
            next_q.buffer = isp_pkg::buffer_reset;
            next_q.stat   = isp_pkg::status_reset;
        end
        next_q.scl_oe = q.cfg[isp_pkg::cfg_link_enable] & ~q.cfg[isp_pkg::cfg_soft_reset]
                        & (next_q.hold | ~q.cfg[isp_pkg::cfg_clock_release]);
        next_q.slew = q.cfg[isp_pkg::cfg_slew_off];
        next_q.irq  = next_q.ie_flag & q.interrupt_enable_one[isp_pkg::irq_bit];
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q         <= '0;
            q.fsm     <= isp_pkg::st_idle;
            q.scl_s   <= 2'b11;
            q.sda_s   <= 2'b11;
            q.scl_q   <= 1'b1;
            q.sda_q   <= 1'b1;
            q.cfg     <= isp_pkg::config_reset;
            q.buffer  <= isp_pkg::buffer_reset;
            q.stat    <= isp_pkg::status_reset;
        end
        else
            q <= next_q;
    end

    // outputs straight from the state register, scl_out and sda_out tied low
    assign prdata         = {24'h000000, q.rdata};
    assign pready         = q.pready;
    assign pslverr        = q.pslverr;
    assign scl_out        = 1'b0;
    assign sda_out        = 1'b0;
    assign scl_oe         = q.scl_oe;
    assign sda_oe         = q.sda_oe;
    assign slew_limit_off = q.slew;
    assign irq            = q.irq;

    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic run;
    assign run = q.cfg[isp_pkg::cfg_link_enable] & ~q.cfg[isp_pkg::cfg_soft_reset];

    port_off_a: assert property (!q.cfg[0] |=> !sda_oe && q.fsm == isp_pkg::st_idle)
        else $error("disabled port drives data");
    soft_reset_a: assert property (q.cfg[5] |=> !q.stat[3] && !scl_oe && !sda_oe)
        else $error("soft reset left link active");
    read_stretch_a: assert property ((run && q.fsm == isp_pkg::st_txw && q.cfg[4]
        && !q.stat[3] && !start_ev && !stop_ev && q.cfg[0] == next_q.cfg[0]
        && q.cfg[5] == next_q.cfg[5]) |=> scl_oe)
        else $error("no clock stretch before send");
    clock_hold_a: assert property ((run && !q.cfg[2]) |=> scl_oe)
        else $error("clock line not held");
    start_flag_a: assert property ((start_ev && run) |=> q.stat[7] && !q.stat[6]
        && q.fsm == isp_pkg::st_addr)
        else $error("start not flagged");
    irq_mask_a: assert property (!q.interrupt_enable_one[3] |=> !irq)
        else $error("masked interrupt reached core");
    coll_reject_a: assert property ((wr_acc && hit && idx == isp_pkg::transfer_buffer_idx
        && q.fsm == isp_pkg::st_tx && run) |=> q.stat[1] && q.buffer == $past(q.buffer))
        else $error("collision write not rejected");
    overrun_keep_a: assert property ((q.stat[0] && !q.cfg[5] && !(wr_acc && hit
        && idx == isp_pkg::link_status_idx)) |=> q.stat[0])
        else $error("overrun flag lost");
    stop_flag_a: assert property ((stop_ev && run && !start_ev) |=> q.stat[6] ##1 !sda_oe)
        else $error("stop not flagged");

    read_match_c: cover property (q.fsm == isp_pkg::st_aack && q.stat[5]);
    overrun_c:    cover property ($rose(q.stat[0]));
    collision_c:  cover property ($rose(q.stat[1]));
    tx_done_c:    cover property (q.fsm == isp_pkg::st_tx ##1 q.fsm == isp_pkg::st_tack);
endmodule : isp_slave
